/* File: shared/dclcd_pkg.sv */
// Shared constants and carriers for the dc line command decoder.
// Assumes a single 250 MHz clock and a synchronous active-high reset.
package dclcd_pkg;

  // Clock rate used to turn times into cycle counts
  localparam int CLK_KHZ = 250000;

  // Keying times in milliseconds, as specified
  localparam int T_GND_DELAY_MS = 60;   // Antenna settle before channel ground
  localparam int T_HOLDOVER_MS  = 180;  // Reverse-burst holdover
  localparam int T_ANT_TAIL_MS  = 30;   // Antenna switch turn-off delay

  // Cycle counts (exact multiples at this rate)
  localparam int GND_DELAY_CYC = T_GND_DELAY_MS * CLK_KHZ;
  localparam int HOLDOVER_CYC  = T_HOLDOVER_MS * CLK_KHZ;
  localparam int ANT_TAIL_CYC  = T_ANT_TAIL_MS * CLK_KHZ;
  localparam int CNT_W         = 26;

  // Register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CFG_ADDR   = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_ADDR  = 8'h04;
  localparam logic [ADDR_W-1:0] LATCH_ADDR = 8'h08;

  // Configuration register fields
  localparam int CFG_PAIRED_BIT  = 0;  // paired_freq_select
  localparam int CFG_CODED_BIT   = 1;  // coded squelch station
  localparam int CFG_JUMPER_A    = 2;  // standalone_jumper_a
  localparam int CFG_JUMPER_B    = 3;  // standalone_jumper_b
  localparam int CFG_W           = 4;
  localparam logic [CFG_W-1:0] CFG_RESET = 4'h0;

  // Decoded line current command strobes, one-hot or none
  typedef struct packed {
    logic pos_low;    // +5.5 mA
    logic pos_high;   // +12.5 mA
    logic neg_small;  // -2.5 mA
    logic neg_low;    // -5.5 mA
    logic neg_high;   // -12.5 mA
  } dclcd_cmd_s;

  // Transmitter keying sequence
  typedef enum logic [2:0] {
    KEY_IDLE,
    KEY_SETTLE,
    KEY_ON,
    KEY_HOLD,
    KEY_TAIL
  } dclcd_key_e;

endpackage

/* File: hdl/dclcd_top.sv */
// DC line command decoder: turns decoded line current commands and
// repeater squelch indications into base station control outputs.
// Assumes command strobes and receiver indications arrive asynchronously
// and are synchronised here; registers sit on a plain strobe port.
`timescale 1ns/1ps
`default_nettype none

// Operation
// (RULE1) High positive command keys channel two
// (RULE2) Negative low command mutes receiver two
// (RULE3) Channel-two turn-on releases receiver-two mute
// (RULE4) Negative small command disables coded squelch
// (RULE5) Any transmit command clears squelch disable
// (RULE6) Paired: positive low sets receiver one
// (RULE7) Paired: positive high sets receiver two
// (RULE8) Receiver latches reset each other
// (RULE9) Receiver latches hold after current removed
// (RULE10) Negative high keys channel one, paging low
// (RULE11) Paging low inhibits coded tone encoder
// (RULE12) Positive low keys with coded tone
// (RULE13) Squelch gate keys on quieted, tone
// (RULE14) Repeater keying drives supplies and mute
// (RULE15) Push-to-talk control grounds channel one
// (RULE16) Standalone: keyed supply drives element ground
// (RULE17) Exciter audio blocked without push-to-talk control
// (RULE18) Line keying overrides repeater keying
// (RULE19) Set-up command raises repeater enable
// (RULE20) Knockdown command lowers repeater enable
// (RULE21) Channel ground delayed 60 ms
// (RULE22) Supply and ground hold 180 ms
// (RULE23) Antenna mute held 30 ms after
// (RULE24) Front end presents one-hot command strobes
module dclcd_top
  import dclcd_pkg::*;
#(
  parameter logic [CNT_W-1:0] GND_DELAY = CNT_W'(GND_DELAY_CYC),
  parameter logic [CNT_W-1:0] HOLDOVER  = CNT_W'(HOLDOVER_CYC),
  parameter logic [CNT_W-1:0] ANT_TAIL  = CNT_W'(ANT_TAIL_CYC)
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              srst,
  // Line command strobes and receiver indications (asynchronous)
  input  wire dclcd_cmd_s        line_cmd,
  input  wire logic              rx_quieted,
  input  wire logic              tone_ok,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // Transmitter control
  output logic                   ptt_n,
  output logic                   tx_channel_one_n,
  output logic                   tx_channel_two_n,
  output logic                   keyed_supply,
  output logic                   delayed_keyed_supply,
  output logic                   exciter_power,
  output logic                   ant_mute_n,
  output logic                   tx_code_inhibit_n,
  output logic                   coded_squelch_tone,
  // Receiver control
  output logic                   rx_channel_one_n,
  output logic                   rx_channel_two_n,
  output logic                   rx_two_silence,
  output logic                   squelch_disable,
  // Repeater control
  output logic                   repeater_enable,
  output logic                   ptt_control,
  output logic                   element_ground_switch,
  output logic                   exciter_audio_gate,
  output logic                   repeat_audio_gate
);

  // Two-stage synchronisers; only stage two is read by logic
  logic [6:0] sync_a;
  logic [6:0] sync_b;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync_a <= 7'h00;
      sync_b <= 7'h00;
    end else begin
      sync_a <= {line_cmd, rx_quieted, tone_ok};
      sync_b <= sync_a;
    end
  end

  dclcd_cmd_s cmd;
  logic       quieted;
  logic       tone_good;
  assign cmd       = sync_b[6:2];
  assign quieted   = sync_b[1];
  assign tone_good = sync_b[0];

  // Configuration register
  logic [CFG_W-1:0] cfg;
  logic             paired;
  logic             coded_station;
  logic             standalone;
  assign paired        = cfg[CFG_PAIRED_BIT];
  assign coded_station = cfg[CFG_CODED_BIT];
  assign standalone    = cfg[CFG_JUMPER_A] & cfg[CFG_JUMPER_B];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg <= CFG_RESET;
    end else if (reg_wr && reg_addr == CFG_ADDR) begin
      cfg <= reg_wdata[CFG_W-1:0];
    end
  end

  // Line keying: any transmit command acts as line push-to-talk
  logic line_ptt;
  assign line_ptt = cmd.pos_low | cmd.pos_high | cmd.neg_high;

  // Latched station functions
  logic silence;
  logic rep_en;
  logic sq_dis;
  logic rx_one;
  logic rx_two;

  // Receiver-two mute: knockdown sets it, channel-two turn-on releases
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      silence <= 1'b0;
    end else if (cmd.neg_low) begin
      silence <= 1'b1; // RULE2
    end else if (cmd.pos_high) begin
      silence <= 1'b0; // RULE3
    end
  end

  // Repeater enable: set-up raises, knockdown lowers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rep_en <= 1'b0;
    end else if (cmd.pos_high) begin
      rep_en <= 1'b1; // RULE19
    end else if (cmd.neg_low) begin
      rep_en <= 1'b0; // RULE20
    end
  end

  // Coded squelch disable; a new disable command wins over a clear
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sq_dis <= 1'b0;
    end else if (cmd.neg_small) begin
      sq_dis <= 1'b1; // RULE4
    end else if (line_ptt) begin
      sq_dis <= 1'b0; // RULE5
    end
  end

  // Paired receiver latches survive loss of line current
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_one <= 1'b0;
      rx_two <= 1'b0;
    end else if (paired && cmd.pos_low) begin
      rx_one <= 1'b1; // RULE6
      rx_two <= 1'b0; // RULE8
    end else if (paired && cmd.pos_high) begin
      rx_two <= 1'b1; // RULE7
      rx_one <= 1'b0; // RULE8
    end
    // Otherwise both hold (RULE9)
  end

  // Squelch gate; line keying takes priority over repeat
  logic gate_open;
  logic rep_ptt;
  assign gate_open = quieted & (~coded_station | tone_good); // RULE13
  assign rep_ptt   = gate_open & rep_en & ~line_ptt;         // RULE18 RULE20

  // Combined keying request drives supplies (RULE14)
  logic key_req;
  assign key_req = line_ptt | rep_ptt; // RULE15

  // Channel two chosen only by line command; repeat always uses one
  logic chan_two;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      chan_two <= 1'b0;
    end else if (line_ptt) begin
      chan_two <= cmd.pos_high; // RULE1
    end else if (rep_ptt) begin
      chan_two <= 1'b0; // RULE15
    end
  end

  // Paging: follows the negative high command while it stands; a latched
  // copy would leak into the next repeater keying as a stray inhibit pulse
  logic paging;
  assign paging = cmd.neg_high; // RULE10

  // Keying sequence: settle, on, holdover, antenna tail
  dclcd_key_e       state;
  dclcd_key_e       next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             grounded;

  always_comb begin
    next_state = state;
    next_cnt   = cnt + CNT_W'(1);
    case (state)
      KEY_IDLE: begin
        next_cnt = '0;
        if (key_req) begin
          next_state = KEY_SETTLE;
        end
      end
      KEY_SETTLE: begin
        if (!key_req) begin
          next_state = KEY_HOLD;
          next_cnt   = '0;
        end else if (cnt == GND_DELAY - CNT_W'(1)) begin
          next_state = KEY_ON; // RULE21
          next_cnt   = '0;
        end
      end
      KEY_ON: begin
        next_cnt = '0;
        if (!key_req) begin
          next_state = KEY_HOLD; // RULE22
        end
      end
      KEY_HOLD: begin
        if (key_req) begin
          next_state = grounded ? KEY_ON : KEY_SETTLE;
          next_cnt   = '0;
        end else if (cnt == HOLDOVER - CNT_W'(1)) begin
          next_state = KEY_TAIL; // RULE22
          next_cnt   = '0;
        end
      end
      KEY_TAIL: begin
        if (key_req) begin
          next_state = KEY_SETTLE;
          next_cnt   = '0;
        end else if (cnt == ANT_TAIL - CNT_W'(1)) begin
          next_state = KEY_IDLE; // RULE23
          next_cnt   = '0;
        end
      end
      default: begin
        next_state = KEY_IDLE;
        next_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= KEY_IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Remembers the ground was given so holdover keeps it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      grounded <= 1'b0;
    end else if (state == KEY_ON) begin
      grounded <= 1'b1;
    end else if (state == KEY_IDLE || state == KEY_TAIL) begin
      grounded <= 1'b0;
    end
  end

  // Derived control levels
  logic supply_live;
  logic gnd_live;
  logic esw;
  assign supply_live = (state == KEY_SETTLE) | (state == KEY_ON) | (state == KEY_HOLD);
  assign gnd_live    = (state == KEY_ON) | ((state == KEY_HOLD) & grounded);
  // Standalone jumpers let keyed supply or its delayed copy ground channel one
  assign esw         = standalone & (key_req | supply_live); // RULE16

  // All pin outputs come from flip-flops, one cycle behind the logic
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ptt_n                 <= 1'b1;
      tx_channel_one_n      <= 1'b1;
      tx_channel_two_n      <= 1'b1;
      keyed_supply          <= 1'b0;
      delayed_keyed_supply  <= 1'b0;
      exciter_power         <= 1'b0;
      ant_mute_n            <= 1'b1;
      tx_code_inhibit_n     <= 1'b1;
      coded_squelch_tone    <= 1'b0;
      rx_channel_one_n      <= 1'b1;
      rx_channel_two_n      <= 1'b1;
      rx_two_silence        <= 1'b0;
      squelch_disable       <= 1'b0;
      repeater_enable       <= 1'b0;
      ptt_control           <= 1'b0;
      element_ground_switch <= 1'b0;
      exciter_audio_gate    <= 1'b0;
      repeat_audio_gate     <= 1'b0;
    end else begin
      ptt_n                 <= ~key_req;                                   // RULE1
      tx_channel_one_n      <= ~((gnd_live & ~chan_two) | esw);            // RULE15
      tx_channel_two_n      <= ~(gnd_live & chan_two);                     // RULE1
      keyed_supply          <= key_req;                                    // RULE14
      delayed_keyed_supply  <= supply_live;                                // RULE22
      exciter_power         <= supply_live;                                // RULE14
      ant_mute_n            <= (state == KEY_IDLE) & ~key_req;             // RULE23
      tx_code_inhibit_n     <= ~(paging & key_req);                        // RULE10
      coded_squelch_tone    <= coded_station & key_req & ~paging;          // RULE11 RULE12
      rx_channel_one_n      <= ~rx_one;
      rx_channel_two_n      <= ~rx_two;
      rx_two_silence        <= silence;
      squelch_disable       <= sq_dis;                                     // RULE4
      repeater_enable       <= rep_en;
      ptt_control           <= rep_ptt;                                    // RULE18
      element_ground_switch <= esw;
      exciter_audio_gate    <= rep_ptt;                                    // RULE17
      repeat_audio_gate     <= rep_ptt;                                    // RULE17
    end
  end

  // Register read: data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        CFG_ADDR:   reg_rdata <= DATA_W'(cfg);
        STAT_ADDR:  reg_rdata <= DATA_W'({gnd_live, supply_live, chan_two, paging, rep_ptt, line_ptt, state});
        LATCH_ADDR: reg_rdata <= DATA_W'({rep_en, sq_dis, silence, rx_two, rx_one});
        default:    reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Checks on the decoder's own behaviour
  a_rx_latch_excl: assert property (@(posedge ref_clk) disable iff (srst) // RULE8
    !(!rx_channel_one_n && !rx_channel_two_n))
    else $error("both receiver channel latches set");

  a_silence_set: assert property (@(posedge ref_clk) disable iff (srst) // RULE2
    cmd.neg_low |=> ##1 rx_two_silence)
    else $error("receiver-two mute not set after knockdown");

  a_silence_release: assert property (@(posedge ref_clk) disable iff (srst) // RULE3
    cmd.pos_high |=> ##1 !rx_two_silence)
    else $error("receiver-two mute not released by channel two");

  a_squelch_clear: assert property (@(posedge ref_clk) disable iff (srst) // RULE5
    (line_ptt && !cmd.neg_small) |=> ##1 !squelch_disable)
    else $error("squelch disable not cleared by keying");

  a_line_priority: assert property (@(posedge ref_clk) disable iff (srst) // RULE18
    line_ptt |=> !ptt_control && !exciter_audio_gate)
    else $error("repeater keying during line keying");

  a_ground_delay: assert property (@(posedge ref_clk) disable iff (srst) // RULE21
    (state == KEY_IDLE && key_req) |=> (!gnd_live) [*8])
    else $error("channel ground before settle delay");

  a_holdover: assert property (@(posedge ref_clk) disable iff (srst) // RULE22
    (state == KEY_ON && !key_req) |=> (supply_live && gnd_live) [*8])
    else $error("supply or ground dropped early in holdover");

  a_tail_mute: assert property (@(posedge ref_clk) disable iff (srst) // RULE23
    $fell(supply_live) && !key_req |-> ##1 !ant_mute_n && !exciter_power)
    else $error("antenna mute released with exciter power");

  a_page_inhibit: assert property (@(posedge ref_clk) disable iff (srst) // RULE11
    cmd.neg_high |=> !tx_code_inhibit_n && !coded_squelch_tone)
    else $error("coded tone sent while paging");

  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (srst)
    !reg_rd |=> reg_rdata == '0)
    else $error("read data outside read cycle");

endmodule

`default_nettype wire

/* File: dv/dclcd_console.sv */
// Remote console model: turns a requested command code into line strobes.
// Assumes the bench changes the request code right after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module dclcd_console
  import dclcd_pkg::*;
(
  // Clock
  input  wire logic       ref_clk,
  // Command request: 0 none, 1 pos low, 2 pos high, 3 neg small, 4 neg low, 5 neg high
  input  wire logic [2:0] req,
  // Decoded line current strobes
  output var  dclcd_cmd_s line_cmd
);

  // One strobe at most; no current means all strobes low
  always_ff @(posedge ref_clk) begin
    case (req)
      3'h1: line_cmd <= '{pos_low: 1'b1, default: 1'b0};
      3'h2: line_cmd <= '{pos_high: 1'b1, default: 1'b0};
      3'h3: line_cmd <= '{neg_small: 1'b1, default: 1'b0};
      3'h4: line_cmd <= '{neg_low: 1'b1, default: 1'b0};
      3'h5: line_cmd <= '{neg_high: 1'b1, default: 1'b0};
      default: line_cmd <= '0;
    endcase
  end

endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the dc line command decoder.
// Assumes shortened keying counts and the console model on the line side.
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import dclcd_pkg::*;
;
  // Short counts keep the run brief; W covers sync plus output latency
  localparam int GD = 20;
  localparam int HO = 40;
  localparam int AT = 10;
  localparam int W  = 7;
  localparam int IDLE = GD + HO + AT + 2 * W;

  logic              ref_clk = 1'b0;
  logic              srst = 1'b1;
  logic [2:0]        req = 3'h0;
  dclcd_cmd_s        line_cmd;
  logic              rx_quieted = 1'b0;
  logic              tone_ok = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 32'h0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              ptt_n, tx_channel_one_n, tx_channel_two_n, keyed_supply, delayed_keyed_supply;
  logic              exciter_power, ant_mute_n, tx_code_inhibit_n, coded_squelch_tone;
  logic              rx_channel_one_n, rx_channel_two_n, rx_two_silence, squelch_disable;
  logic              repeater_enable, ptt_control, element_ground_switch, exciter_audio_gate;
  logic              repeat_audio_gate;
  int                n_errors = 0;
  int                n_tests = 0;

  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;

  dclcd_console dclcd_console_i (.ref_clk(ref_clk), .req(req), .line_cmd(line_cmd));

  dclcd_top #(.GND_DELAY(26'(GD)), .HOLDOVER(26'(HO)), .ANT_TAIL(26'(AT))) dclcd_top_i (
    .ref_clk(ref_clk), .srst(srst), .line_cmd(line_cmd), .rx_quieted(rx_quieted), .tone_ok(tone_ok),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ptt_n(ptt_n), .tx_channel_one_n(tx_channel_one_n), .tx_channel_two_n(tx_channel_two_n),
    .keyed_supply(keyed_supply), .delayed_keyed_supply(delayed_keyed_supply),
    .exciter_power(exciter_power), .ant_mute_n(ant_mute_n), .tx_code_inhibit_n(tx_code_inhibit_n),
    .coded_squelch_tone(coded_squelch_tone), .rx_channel_one_n(rx_channel_one_n),
    .rx_channel_two_n(rx_channel_two_n), .rx_two_silence(rx_two_silence),
    .squelch_disable(squelch_disable), .repeater_enable(repeater_enable), .ptt_control(ptt_control),
    .element_ground_switch(element_ground_switch), .exciter_audio_gate(exciter_audio_gate),
    .repeat_audio_gate(repeat_audio_gate));

  task automatic results();
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Advance n edges, then look once the edge updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // Hang guard, well beyond the expected run length
  initial begin
    repeat (4000) @(posedge ref_clk);
    n_errors++;
    results();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    tick(3);
    chk(ptt_n, 1'b1);
    chk(ant_mute_n, 1'b1);
    chk(repeater_enable, 1'b0);
    // Paired, coded station; status write must be ignored
    wr(CFG_ADDR, 32'h3);
    wr(STAT_ADDR, 32'hf);
    rd(CFG_ADDR, 32'h3);
    rd(8'h0c, 32'h0);
    @(posedge ref_clk) req <= 3'h3;
    tick(W);
    chk(squelch_disable, 1'b1);
    @(posedge ref_clk) req <= 3'h4;
    tick(W);
    chk(rx_two_silence, 1'b1);
    chk(repeater_enable, 1'b0);
    chk(squelch_disable, 1'b1);
    // Channel two keying clears both latched conditions
    @(posedge ref_clk) req <= 3'h2;
    tick(W);
    chk(ptt_n, 1'b0);
    chk(keyed_supply, 1'b1);
    chk(rx_two_silence, 1'b0);
    chk(squelch_disable, 1'b0);
    chk(repeater_enable, 1'b1);
    chk(rx_channel_two_n, 1'b0);
    chk(tx_channel_two_n, 1'b1);
    tick(GD);
    chk(tx_channel_two_n, 1'b0);
    chk(tx_channel_one_n, 1'b1);
    rd(LATCH_ADDR, 32'h12);
    @(posedge ref_clk) req <= 3'h0;
    tick(W);
    chk(ptt_n, 1'b1);
    chk(tx_channel_two_n, 1'b0);
    chk(delayed_keyed_supply, 1'b1);
    chk(rx_channel_two_n, 1'b0);
    tick(HO);
    chk(tx_channel_two_n, 1'b1);
    chk(delayed_keyed_supply, 1'b0);
    chk(exciter_power, 1'b0);
    chk(ant_mute_n, 1'b0);
    tick(12);
    chk(ant_mute_n, 1'b1);
    // Channel one with coded tone, paired receiver one
    @(posedge ref_clk) req <= 3'h1;
    tick(W);
    chk(coded_squelch_tone, 1'b1);
    chk(rx_channel_one_n, 1'b0);
    chk(rx_channel_two_n, 1'b1);
    @(posedge ref_clk) req <= 3'h0;
    tick(IDLE);
    // Paging keys channel one without tone
    @(posedge ref_clk) req <= 3'h5;
    tick(W + GD);
    chk(tx_code_inhibit_n, 1'b0);
    chk(tx_channel_one_n, 1'b0);
    chk(coded_squelch_tone, 1'b0);
    @(posedge ref_clk) req <= 3'h0;
    tick(IDLE);
    // Repeater keying needs the tone in a coded station
    @(posedge ref_clk) rx_quieted <= 1'b1;
    tick(W);
    chk(ptt_control, 1'b0);
    @(posedge ref_clk) tone_ok <= 1'b1;
    tick(W);
    chk(ptt_control, 1'b1);
    chk(ptt_n, 1'b0);
    chk(ant_mute_n, 1'b0);
    chk(exciter_power, 1'b1);
    chk(exciter_audio_gate, 1'b1);
    chk(repeat_audio_gate, 1'b1);
    chk(element_ground_switch, 1'b0);
    tick(GD);
    chk(tx_channel_one_n, 1'b0);
    @(posedge ref_clk) req <= 3'h1;
    tick(W);
    chk(ptt_control, 1'b0);
    chk(exciter_audio_gate, 1'b0);
    chk(repeat_audio_gate, 1'b0);
    @(posedge ref_clk) req <= 3'h0;
    tick(W);
    chk(ptt_control, 1'b1);
    @(posedge ref_clk) req <= 3'h4;
    tick(W);
    chk(repeater_enable, 1'b0);
    chk(ptt_control, 1'b0);
    @(posedge ref_clk);
    req <= 3'h0;
    rx_quieted <= 1'b0;
    tone_ok <= 1'b0;
    tick(IDLE);
    // Standalone repeater: both jumpers, no coded squelch, not paired
    wr(CFG_ADDR, 32'hc);
    @(posedge ref_clk) req <= 3'h2;
    tick(W);
    chk(rx_channel_one_n, 1'b0);
    chk(rx_channel_two_n, 1'b1);
    chk(rx_two_silence, 1'b0);
    chk(repeater_enable, 1'b1);
    @(posedge ref_clk) req <= 3'h0;
    tick(IDLE);
    @(posedge ref_clk) rx_quieted <= 1'b1;
    tick(W);
    chk(element_ground_switch, 1'b1);
    chk(tx_channel_one_n, 1'b0);
    @(posedge ref_clk) rx_quieted <= 1'b0;
    tick(W);
    chk(tx_channel_one_n, 1'b0);
    tick(IDLE);
    results();
  end

endmodule
`default_nettype wire
